// ==== common/aspc_pkg.sv ====
// audio serial port control: shared constants, register map and carrier types
// assumes a 32-bit avalon-mm master using byte addresses; one word per register
package aspc_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // register index; byte address is four times the index
  localparam logic [5:0] IDX_CHAN_SRC = 6'h18;
  localparam logic [5:0] IDX_FMT_SLOT = 6'h19;
  localparam logic [5:0] IDX_BIT_DIV = 6'h1A;
  localparam logic [5:0] IDX_FRAME_CTL = 6'h1B;
  localparam logic [5:0] IDX_STATUS = 6'h1C;

  localparam logic [15:0] RST_CHAN_SRC = 16'h0050;
  localparam logic [15:0] RST_FMT_SLOT = 16'h000A;
  localparam logic [15:0] RST_BIT_DIV = 16'h0004;
  localparam logic [15:0] RST_FRAME_CTL = 16'h0040;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POS_TXL_SRC = 7;
  localparam int POS_TXR_SRC = 6;
  localparam int POS_RXL_SRC = 5;
  localparam int POS_RXR_SRC = 4;
  localparam int POS_RX_TDM = 13;
  localparam int POS_RX_SLOT = 12;
  localparam int POS_TX_TDM = 11;
  localparam int POS_TX_SLOT = 10;
  localparam int POS_HIGHZ = 8;
  localparam int POS_BIT_INV = 7;
  localparam int POS_BIT_DIR = 6;
  localparam int POS_FRAME_INV = 4;
  localparam int POS_WL = 2;
  localparam int POS_FMT = 0;
  localparam int POS_DIV = 0;
  localparam int POS_FRAME_DIR = 11;
  localparam int POS_RATE = 0;
  localparam int POS_ST_RUN = 0;
  localparam int POS_ST_FRAME = 1;
  localparam int POS_ST_RIGHT = 2;

  // ------------------------------------------------------------
  // serial timing
  // ------------------------------------------------------------
  localparam int SAMPLE_BITS = 24;
  localparam logic [5:0] SAMPLE_BITS6 = 6'h18;
  localparam logic [5:0] WL_16 = 6'h10;
  localparam logic [5:0] WL_20 = 6'h14;
  localparam logic [5:0] WL_24 = 6'h18;
  localparam logic [5:0] WL_32 = 6'h20;
  localparam int START_LJ = 1;
  localparam int START_I2S = 2;
  localparam int START_DSP_A = 2;
  localparam int START_DSP_B = 1;
  localparam logic [10:0] FRAME_RATE_MIN = 11'h008;
  localparam logic [10:0] POS_FIRST = 11'h001;
  // divider works in quarter units of the system clock period
  localparam logic [8:0] DIV_STEP = 9'h004;
  localparam logic [4:0] DIV_CODE_MAX = 5'h14;

  typedef enum logic [1:0] {
    FMT_RJ = 2'h0,
    FMT_LJ = 2'h1,
    FMT_I2S = 2'h2,
    FMT_DSP = 2'h3
  } aspc_fmt_type;

  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } aspc_pair_type;

  typedef struct packed {
    logic active;
    logic isRight;
    logic [5:0] bitIdx;
  } aspc_slot_type;

endpackage

// ==== hw/aspc_top.sv ====
// audio serial port control: registers, clock generation and serial engine
// assumes clk is the system clock; serial pins are asynchronous to it
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module aspc_top
  import aspc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // audio paths
  input wire logic micEnable,
  input wire logic dacEnable,
  input wire aspc_pair_type micSample,
  output aspc_pair_type dacSample,
  output logic dacSampleValid,
  // serial port pins
  input wire logic bitClkIn,
  output logic bitClkOut,
  output logic bitClkOe,
  input wire logic frameClkIn,
  output logic frameClkOut,
  output logic frameClkOe,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [3:0] be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // position of a bit period inside a half (or a dsp frame) mapped onto a word slot
  function automatic aspc_slot_type slotInfo(input logic [10:0] pos,
                                             input logic [10:0] halfLen,
                                             input aspc_fmt_type fmt,
                                             input logic [5:0] wl,
                                             input logic tdm,
                                             input logic sel,
                                             input logic modeB,
                                             input logic rightHalf);
    int span;
    int start;
    int idx;
    aspc_slot_type s;
    span = (fmt == FMT_DSP) ? 2 * int'(wl) : int'(wl);
    case (fmt)
      FMT_RJ: start = int'(halfLen) - (tdm ? 2 * span : span) + 1;
      FMT_LJ: start = START_LJ;
      FMT_I2S: start = START_I2S;
      default: start = modeB ? START_DSP_B : START_DSP_A;
    endcase
    idx = int'(pos) - start - ((tdm && sel) ? span : 0);
    s.active = (idx >= 0) && (idx < span);
    s.isRight = (fmt == FMT_DSP) ? (idx >= int'(wl)) : rightHalf;
    s.bitIdx = (idx >= int'(wl)) ? 6'(idx - int'(wl)) : 6'(idx);
    return s;
  endfunction

  // ------------------------------------------------------------
  // registers and bus
  // ------------------------------------------------------------
  logic [15:0] chanSrc_ff, fmtSlot_ff, bitDiv_ff, frameCtl_ff;
  logic waitReq_ff;
  logic [DATA_W-1:0] readData_ff;
  logic [5:0] regIdx;
  logic wrCommit;
  logic [15:0] rdMux;
  logic [15:0] statusWord;

  assign regIdx = avs_address[ADDR_W-1:2];
  assign wrCommit = avs_write && !waitReq_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chanSrc_ff <= RST_CHAN_SRC;
      fmtSlot_ff <= RST_FMT_SLOT;
      bitDiv_ff <= RST_BIT_DIV;
      frameCtl_ff <= RST_FRAME_CTL;
    end else if (wrCommit) begin
      case (regIdx)
        IDX_CHAN_SRC: chanSrc_ff <= mergeWrite(chanSrc_ff, avs_writedata, avs_byteenable);
        IDX_FMT_SLOT: fmtSlot_ff <= mergeWrite(fmtSlot_ff, avs_writedata, avs_byteenable);
        IDX_BIT_DIV: bitDiv_ff <= mergeWrite(bitDiv_ff, avs_writedata, avs_byteenable);
        IDX_FRAME_CTL: frameCtl_ff <= mergeWrite(frameCtl_ff, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // one wait cycle, then a single low cycle that completes the transfer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= !((avs_read || avs_write) && waitReq_ff);
    end
  end

  always_comb begin
    case (regIdx)
      IDX_CHAN_SRC: rdMux = chanSrc_ff;
      IDX_FMT_SLOT: rdMux = fmtSlot_ff;
      IDX_BIT_DIV: rdMux = bitDiv_ff;
      IDX_FRAME_CTL: rdMux = frameCtl_ff;
      IDX_STATUS: rdMux = statusWord;
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readData_ff <= 32'h00000000;
    end else if (avs_read && waitReq_ff) begin
      readData_ff <= {16'h0000, rdMux};
    end
  end

  assign avs_waitrequest = waitReq_ff;
  assign avs_readdata = readData_ff;

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  aspc_fmt_type fmt;
  logic [5:0] wlBits;
  logic bitInv, frameInv, bitDir, frameDir, highZ;
  logic rxTdm, rxSel, txTdm, txSel;
  logic runClocks, leftLevel;
  logic [10:0] frameRate;

  assign fmt = aspc_fmt_type'(fmtSlot_ff[POS_FMT +: 2]);
  always_comb begin
    case (fmtSlot_ff[POS_WL +: 2])
      2'h0: wlBits = WL_16;
      2'h1: wlBits = WL_20;
      2'h2: wlBits = WL_24;
      default: wlBits = WL_32;
    endcase
  end
  assign bitInv = fmtSlot_ff[POS_BIT_INV];
  assign frameInv = fmtSlot_ff[POS_FRAME_INV];
  assign bitDir = fmtSlot_ff[POS_BIT_DIR];
  assign frameDir = frameCtl_ff[POS_FRAME_DIR];
  assign highZ = fmtSlot_ff[POS_HIGHZ];
  assign rxTdm = fmtSlot_ff[POS_RX_TDM];
  assign rxSel = fmtSlot_ff[POS_RX_SLOT];
  assign txTdm = fmtSlot_ff[POS_TX_TDM];
  assign txSel = fmtSlot_ff[POS_TX_SLOT];
  assign runClocks = micEnable || dacEnable;
  // left half level: high for the justified formats, low for i2s and dsp; frameInv inverts it
  assign leftLevel = ((fmt == FMT_LJ) || (fmt == FMT_RJ)) ^ frameInv;
  assign frameRate = (frameCtl_ff[POS_RATE +: 11] < FRAME_RATE_MIN) ?
                     FRAME_RATE_MIN : frameCtl_ff[POS_RATE +: 11];

  // ------------------------------------------------------------
  // pin synchronisers: bit clock, frame clock, data
  // ------------------------------------------------------------
  logic [2:0] pinMeta_ff, pinSync_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_ff <= 3'h0;
      pinSync_ff <= 3'h0;
    end else begin
      pinMeta_ff <= {serialDataIn, frameClkIn, bitClkIn};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // ------------------------------------------------------------
  // master bit clock divider
  // ------------------------------------------------------------
  logic [7:0] divHalves;
  logic [8:0] divAcc_ff, divSum;
  logic bitClkGen_ff;

  // twice the divisor; codes past the table fall back to the default
  always_comb begin
    case (bitDiv_ff[POS_DIV +: 5])
      5'h00: divHalves = 8'h02;
      5'h01: divHalves = 8'h03;
      5'h02: divHalves = 8'h04;
      5'h03: divHalves = 8'h06;
      5'h05: divHalves = 8'h0A;
      5'h06: divHalves = 8'h0B;
      5'h07: divHalves = 8'h0C;
      5'h08: divHalves = 8'h10;
      5'h09: divHalves = 8'h14;
      5'h0A: divHalves = 8'h16;
      5'h0B: divHalves = 8'h18;
      5'h0C: divHalves = 8'h20;
      5'h0D: divHalves = 8'h28;
      5'h0E: divHalves = 8'h2C;
      5'h0F: divHalves = 8'h30;
      5'h10: divHalves = 8'h32;
      5'h11: divHalves = 8'h3C;
      5'h12: divHalves = 8'h40;
      5'h13: divHalves = 8'h58;
      DIV_CODE_MAX: divHalves = 8'h60;
      default: divHalves = 8'h08;
    endcase
  end

  assign divSum = divAcc_ff + DIV_STEP;

  // fractional divisors alternate half periods; below 2 it saturates at clk/2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divAcc_ff <= 9'h000;
      bitClkGen_ff <= 1'b0;
    end else if (!runClocks) begin
      divAcc_ff <= 9'h000;
      bitClkGen_ff <= 1'b0;
    end else if (divSum >= {1'b0, divHalves}) begin
      bitClkGen_ff <= !bitClkGen_ff;
      divAcc_ff <= (divSum >= {divHalves, 1'b0}) ? 9'h000 : divSum - {1'b0, divHalves};
    end else begin
      divAcc_ff <= divSum;
    end
  end

  // ------------------------------------------------------------
  // bit clock edges and master frame clock
  // ------------------------------------------------------------
  logic bitClkEff, bitClkPrev_ff, bitRise, bitFall;
  logic [10:0] frameCnt_ff, nxtFrameCnt;
  logic frameGen_ff, frameSrc;

  // mixed mode: the frame divider counts whichever bit clock is in use
  assign bitClkEff = (bitDir ? bitClkGen_ff : pinSync_ff[0]) ^ bitInv;
  assign bitRise = bitClkEff && !bitClkPrev_ff;
  assign bitFall = !bitClkEff && bitClkPrev_ff;
  assign nxtFrameCnt = (frameCnt_ff >= frameRate - 11'h001) ? 11'h000 : frameCnt_ff + 11'h001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitClkPrev_ff <= 1'b0;
    end else begin
      bitClkPrev_ff <= bitClkEff;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frameCnt_ff <= 11'h000;
      frameGen_ff <= 1'b0;
    end else if (!runClocks) begin
      frameCnt_ff <= 11'h000;
      frameGen_ff <= 1'b0;
    end else if (bitFall) begin
      frameCnt_ff <= nxtFrameCnt;
      if (fmt == FMT_DSP) begin
        frameGen_ff <= (nxtFrameCnt == 11'h000);
      end else begin
        frameGen_ff <= (nxtFrameCnt < (frameRate >> 1)) ? leftLevel : !leftLevel;
      end
    end
  end

  assign frameSrc = frameDir ? frameGen_ff : pinSync_ff[1];

  // ------------------------------------------------------------
  // frame position tracking
  // ------------------------------------------------------------
  logic frameLast_ff, rightHalf_ff, newHalf, rightNow;
  logic [10:0] posCnt_ff, halfLen_ff, nxtPos;
  aspc_slot_type rxInfo, txInfo;

  assign newHalf = (fmt == FMT_DSP) ? (frameSrc && !frameLast_ff) : (frameSrc != frameLast_ff);
  assign nxtPos = newHalf ? POS_FIRST : ((posCnt_ff == 11'h7FF) ? posCnt_ff : posCnt_ff + 11'h001);
  assign rightNow = frameSrc != leftLevel;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frameLast_ff <= 1'b0;
      posCnt_ff <= 11'h000;
      halfLen_ff <= 11'h000;
      rightHalf_ff <= 1'b0;
    end else if (bitRise) begin
      frameLast_ff <= frameSrc;
      posCnt_ff <= nxtPos;
      rightHalf_ff <= rightNow;
      if (newHalf) begin
        halfLen_ff <= posCnt_ff;
      end
    end
  end

  assign rxInfo = slotInfo(nxtPos, halfLen_ff, fmt, wlBits, rxTdm, rxSel, frameInv,
                           rightNow);
  assign txInfo = slotInfo(nxtPos, halfLen_ff, fmt, wlBits, txTdm, txSel, frameInv,
                           rightNow);

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  logic [23:0] rxShift_ff, rxLeft_ff, rxWord, rxFull;
  logic rxLast;
  aspc_pair_type dacSample_ff;
  logic dacValid_ff;

  assign rxLast = rxInfo.bitIdx == wlBits - 6'h01;
  assign rxFull = (wlBits == WL_32) ? rxShift_ff : {rxShift_ff[22:0], pinSync_ff[2]};
  assign rxWord = (wlBits >= WL_24) ? rxFull : rxFull << (SAMPLE_BITS6 - wlBits);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxShift_ff <= 24'h000000;
      rxLeft_ff <= 24'h000000;
      dacSample_ff <= '0;
      dacValid_ff <= 1'b0;
    end else begin
      dacValid_ff <= 1'b0;
      if (bitRise && rxInfo.active) begin
        if (rxInfo.bitIdx < SAMPLE_BITS6) begin
          rxShift_ff <= {rxShift_ff[22:0], pinSync_ff[2]};
        end
        if (rxLast && !rxInfo.isRight) begin
          rxLeft_ff <= rxWord;
        end
        if (rxLast && rxInfo.isRight) begin
          dacSample_ff.left <= chanSrc_ff[POS_RXL_SRC] ? rxWord : rxLeft_ff;
          dacSample_ff.right <= chanSrc_ff[POS_RXR_SRC] ? rxWord : rxLeft_ff;
          dacValid_ff <= 1'b1;
        end
      end
    end
  end

  assign dacSample = dacSample_ff;
  assign dacSampleValid = dacValid_ff;

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------
  aspc_pair_type txPair_ff, txRouted;
  logic txLatch, txOeRaw_ff, txData_ff;
  logic [23:0] txWord;

  assign txRouted.left = chanSrc_ff[POS_TXL_SRC] ? micSample.right : micSample.left;
  assign txRouted.right = chanSrc_ff[POS_TXR_SRC] ? micSample.right : micSample.left;
  // a new frame may start on the very fall that carries its msb
  assign txLatch = newHalf && ((fmt == FMT_DSP) || !rightNow);
  always_comb begin
    if (txInfo.isRight) begin
      txWord = txLatch ? txRouted.right : txPair_ff.right;
    end else begin
      txWord = txLatch ? txRouted.left : txPair_ff.left;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txPair_ff <= '0;
      txOeRaw_ff <= 1'b0;
      txData_ff <= 1'b0;
    end else if (bitFall) begin
      if (txLatch) begin
        txPair_ff <= txRouted;
      end
      if (txInfo.active && (txInfo.bitIdx < SAMPLE_BITS6)) begin
        txOeRaw_ff <= 1'b1;
        txData_ff <= txWord[5'(SAMPLE_BITS - 1) - 5'(txInfo.bitIdx)];
      end else begin
        txOeRaw_ff <= !txTdm && !txInfo.active;
        txData_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  logic bitOe_ff, frameOe_ff, dataOe_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitOe_ff <= 1'b0;
      frameOe_ff <= 1'b0;
      dataOe_ff <= 1'b0;
    end else begin
      bitOe_ff <= bitDir && !highZ;
      frameOe_ff <= frameDir && !highZ;
      dataOe_ff <= txOeRaw_ff && !highZ;
    end
  end

  assign bitClkOut = bitClkGen_ff;
  assign bitClkOe = bitOe_ff;
  assign frameClkOut = frameGen_ff;
  assign frameClkOe = frameOe_ff;
  assign serialDataOut = txData_ff;
  assign serialDataOe = dataOe_ff;

  assign statusWord = {13'h0000, rightHalf_ff, frameSrc, runClocks};

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_highz_release;
    @(posedge clk) disable iff (!rst_b)
    highZ |=> !bitClkOe && !frameClkOe && !serialDataOe;
  endproperty
  a_highz_release: assert property (p_highz_release)
    else $error("port pin driven while high impedance bit set");

  property p_bit_dir;
    @(posedge clk) disable iff (!rst_b)
    (!highZ && $changed(bitDir)) |=> (bitClkOe == $past(bitDir));
  endproperty
  a_bit_dir: assert property (p_bit_dir)
    else $error("bit clock enable does not follow its direction bit");

  property p_frame_dir;
    @(posedge clk) disable iff (!rst_b)
    (!highZ && frameDir && !bitDir) |=> frameClkOe && !bitClkOe;
  endproperty
  a_frame_dir: assert property (p_frame_dir)
    else $error("frame clock enable not independent of bit clock");

  property p_clocks_idle;
    @(posedge clk) disable iff (!rst_b)
    !runClocks [*3] |-> !bitClkOut && !frameClkOut && $stable(bitClkOut);
  endproperty
  a_clocks_idle: assert property (p_clocks_idle)
    else $error("master clocks run with all channels disabled");

  property p_div_default;
    @(posedge clk) disable iff (!rst_b)
    (runClocks && bitDiv_ff[POS_DIV +: 5] == RST_BIT_DIV[4:0] && $changed(bitClkGen_ff)
      && $stable(bitDiv_ff)) ##1 runClocks |-> $stable(bitClkGen_ff) ##1 $changed(bitClkGen_ff);
  endproperty
  a_div_default: assert property (p_div_default)
    else $error("default divider half period is not two clocks");

  property p_frame_wrap;
    @(posedge clk) disable iff (!rst_b)
    (runClocks && bitFall && frameCnt_ff == frameRate - 11'h001) |=> frameCnt_ff == 11'h000;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("frame counter does not wrap at the rate value");

  property p_tdm_release;
    @(posedge clk) disable iff (!rst_b)
    (bitFall && txTdm && !txInfo.active) |=> !txOeRaw_ff ##1 !serialDataOe;
  endproperty
  a_tdm_release: assert property (p_tdm_release)
    else $error("data pin driven outside own slot");

  property p_low_bits_undriven;
    @(posedge clk) disable iff (!rst_b)
    (bitFall && txInfo.active && txInfo.bitIdx >= SAMPLE_BITS6) |=> ##1 !serialDataOe;
  endproperty
  a_low_bits_undriven: assert property (p_low_bits_undriven)
    else $error("padding bit of a 32-bit word was driven");

  property p_rx_route;
    @(posedge clk) disable iff (!rst_b)
    (bitRise && rxInfo.active && rxLast && rxInfo.isRight && !chanSrc_ff[POS_RXL_SRC])
      |=> dacSampleValid && dacSample.left == $past(rxLeft_ff);
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("left converter did not get the left channel word");

endmodule
`default_nettype wire

// ==== tb/aspc_far_end.sv ====
// far-end model: slave-bus party driving bit clock, frame clock and data
// assumes left-justified 24-bit words, data sampled on rising bit clock
`timescale 1ns/1ns
`default_nettype none
module aspc_far_end
  import aspc_pkg::*;
(
  // control
  input wire logic run,
  input wire aspc_pair_type words,
  output aspc_pair_type got,
  // pins
  output logic bck,
  output logic lrck,
  output logic sdo,
  input wire logic din
);
  int bitN = 0;
  initial begin
    bck = 1'b0;
    lrck = 1'b0;
    sdo = 1'b0;
    got = '0;
  end
  // clock still outside frames; 4 clk phases respect the sync limit
  always begin
    #160;
    if (run) begin
      bck = ~bck;
      if (bck && bitN < 24) begin
        if (lrck) got.left[23-bitN] = din;
        else got.right[23-bitN] = din;
      end
      if (!bck) begin
        bitN = (bitN + 1) % 32;
        if (bitN == 0) lrck = ~lrck;
        sdo = (bitN < 24) ? (lrck ? words.left[23-bitN] : words.right[23-bitN]) : ~sdo;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/audio_serial_port_control_tb_top.sv ====
// bench: register bus, pin directions, master clock gating and reception
// assumes the far-end model stands in for the slave-mode bus party
`timescale 1ns/1ns
`default_nettype none
module audio_serial_port_control_tb_top
  import aspc_pkg::*;
;
  logic clk, rst_b, rd, wr, waitReq, micEn, dacEn, dacValid, run;
  logic bco, bcoe, fco, fcoe, sdo, sdoe, pBck, pLr, pSd;
  logic [7:0] addr;
  logic [3:0] byteen;
  logic [31:0] wdata, rdata, q;
  aspc_pair_type mic, dac, pair, txSeen;
  int failures = 0;
  int comparisons = 0;
  aspc_top u_aspc_top (.clk(clk), .rst_b(rst_b), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(byteen), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .micEnable(micEn), .dacEnable(dacEn), .micSample(mic),
    .dacSample(dac), .dacSampleValid(dacValid), .bitClkIn(bcoe ? bco : pBck), .bitClkOut(bco),
    .bitClkOe(bcoe), .frameClkIn(fcoe ? fco : pLr), .frameClkOut(fco), .frameClkOe(fcoe),
    .serialDataIn(pSd), .serialDataOut(sdo), .serialDataOe(sdoe));
  // a released data pin reads inverted: no pull is modelled on the line
  aspc_far_end u_aspc_far_end (.run(run), .words(pair), .got(txSeen), .bck(pBck), .lrck(pLr),
    .sdo(pSd), .din(sdoe ? sdo : !sdo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task summarize();
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitReq !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask
  task test_reset();
    logic [7:0] a [5] = '{8'h60, 8'h64, 8'h68, 8'h6C, 8'h80};
    logic [31:0] e [5] = '{32'h50, 32'hA, 32'h4, 32'h40, 32'h0};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk("regRead", e[i], q);
    end
  endtask
  task test_pins();
    bus(1'b1, 8'h64, 32'h4A);
    repeat (3) @(posedge clk);
    chk("bitClkOe", 1, bcoe);
    chk("frameClkOe", 0, fcoe);
    bus(1'b1, 8'h6C, 32'h840);
    repeat (3) @(posedge clk);
    chk("frameClkOe", 1, fcoe);
    bus(1'b1, 8'h64, 32'hA);
    repeat (3) @(posedge clk);
    chk("mixedOe", 2'b01, {bcoe, fcoe});
    bus(1'b1, 8'h64, 32'h14A);
    repeat (3) @(posedge clk);
    chk("allOe", 0, {bcoe, fcoe, sdoe});
    bus(1'b1, 8'h64, 32'h4A);
  endtask
  task toggles(output int n);
    logic last;
    n = 0;
    last = bco;
    repeat (64) begin
      @(posedge clk);
      if (bco !== last) n++;
      last = bco;
    end
  endtask
  task test_master();
    int n;
    logic last;
    toggles(n);
    chk("idleToggles", 0, n);
    micEn <= 1'b1;
    repeat (4) @(posedge clk);
    toggles(n);
    chk("div4Toggles", 1, n inside {[30:33]});
    micEn <= 1'b0;
    dacEn <= 1'b1;
    n = 0;
    last = fco;
    repeat (200) begin
      @(posedge clk);
      if (fco !== last) n++;
      last = fco;
    end
    chk("frameToggles", 2, n);
    dacEn <= 1'b0;
    bus(1'b1, 8'h64, 32'hA);
    bus(1'b1, 8'h6C, 32'h40);
  endtask
  task test_rx();
    int n, v;
    n = 0;
    v = 0;
    bus(1'b1, 8'h60, 32'h60);
    bus(1'b1, 8'h64, 32'h809);
    run <= 1'b1;
    while (v < 2 && n < 3000) begin
      @(posedge clk);
      n++;
      if (dacValid === 1'b1) v++;
    end
    if (v < 2) begin
      failures++;
      summarize();
    end
    chk("dacLeft", pair.right, dac.left);
    chk("dacRight", pair.left, dac.right);
    chk("txLeft", mic.left, txSeen.left);
    chk("txRight", mic.right, txSeen.right);
  endtask
  initial begin
    rst_b = 1'b0;
    {addr, rd, wr, wdata, byteen} = {8'h0, 2'b00, 32'h0, 4'hF};
    {micEn, dacEn, run} = 3'b000;
    mic = {24'h123456, 24'h654321};
    pair = {24'hA5C3E1, 24'h5A3C1E};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_pins();
    test_master();
    test_rx();
    summarize();
  end
endmodule
`default_nettype wire
